//--- mvor_consts.svh
// constants for the move/or instruction execution block
// assumes a 14-bit instruction word and 8-bit data path
`ifndef MVOR_CONSTS_SVH
`define MVOR_CONSTS_SVH
`define OPC_OR_TOP     6'h04
`define OPC_COPY_TOP   6'h08
`define OPC_STORE_TOP  7'h01
`define OPC_LIT_TOP    4'hC
`define DEST_BIT       7
`define ACC_RESET      8'h00
`define ZERO_RESET     1'h0
`endif

//--- mvor_pkg.sv
// types for the move/or instruction execution block
// assumes mvor_consts.svh for numeric constants
`default_nettype none
package mvor_pkg;
   typedef enum logic [1:0] {
      PH_DECODE  = 2'b00,
      PH_READ    = 2'b01,
      PH_PROCESS = 2'b10,
      PH_WRITE   = 2'b11
   } phase_type;
   typedef enum logic [2:0] {
      OP_NONE  = 3'b000,
      OP_OR    = 3'b001,
      OP_LIT   = 3'b010,
      OP_COPY  = 3'b011,
      OP_STORE = 3'b100
   } op_type;
   typedef struct packed {
      logic       we;
      logic [6:0] addr;
      logic [7:0] data;
   } file_write_type;
endpackage
`default_nettype wire

//--- mvor_decode.sv
// opcode decoder for the four handled instructions
// assumes a 14-bit instruction word
`timescale 1ns/1ps
`default_nettype none
`include "mvor_consts.svh"
module mvor_decode
   import mvor_pkg::*;
(
   // instruction
   input  wire logic [13:0] instr_in,
   // decoded op
   output op_type           op_out
);
   always_comb begin
      if (instr_in[13:8] == `OPC_OR_TOP) begin
         op_out = OP_OR;
      end else if (instr_in[13:8] == `OPC_COPY_TOP) begin
         op_out = OP_COPY;
      end else if (instr_in[13:7] == `OPC_STORE_TOP) begin
         op_out = OP_STORE;
      end else if (instr_in[13:10] == `OPC_LIT_TOP) begin
         op_out = OP_LIT; // bits 9:8 are don't care
      end else begin
         op_out = OP_NONE;
      end
   end
endmodule
`default_nettype wire

//--- mvor_exec.sv
// execution of or/literal/copy/store over four clock phases
// assumes the register file answers read data combinationally
`timescale 1ns/1ps
`default_nettype none
`include "mvor_consts.svh"
module mvor_exec
   import mvor_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rstn_in,
   // instruction stream
   input  wire logic [13:0] instr_in,
   output logic             instr_ready_out,
   // register file
   output logic [6:0]       file_raddr_out,
   input  wire logic [7:0]  file_rdata_in,
   output file_write_type   file_wr_out,
   // architectural state
   output logic [7:0]       acc_out,
   output logic             zero_flag_out,
   output phase_type        phase_out
);
   typedef struct packed {
      phase_type      phase;
      op_type         op;
      logic [13:0]    instr;
      logic [7:0]     operand;
      logic [7:0]     result;
      logic [7:0]     acc;
      logic           zero;
      file_write_type wr;
   } state_type;

   state_type st;
   state_type next_st;
   op_type    dec_op;

   mvor_decode u_dec (
      .instr_in (instr_in),
      .op_out   (dec_op)
   );

   ////////////////////////////////////////////////////////////////////
   // one instruction per four phases; the next word is taken at decode
   always_comb begin
      next_st = st;
      next_st.wr.we = 1'b0;
      case (st.phase)
         PH_DECODE: begin
            next_st.instr = instr_in;
            next_st.op    = dec_op;
            next_st.phase = PH_READ;
         end
         PH_READ: begin
            if (st.op == OP_LIT) begin
               next_st.operand = st.instr[7:0];
            end else begin
               next_st.operand = file_rdata_in;
            end
            next_st.phase = PH_PROCESS;
         end
         PH_PROCESS: begin
            case (st.op)
               OP_OR:    next_st.result = st.acc | st.operand;
               OP_STORE: next_st.result = st.acc;
               default:  next_st.result = st.operand;
            endcase
            next_st.phase = PH_WRITE;
         end
         PH_WRITE: begin
            next_st.phase = PH_DECODE;
            next_st.wr.addr = st.instr[6:0];
            next_st.wr.data = st.result;
            case (st.op)
               OP_OR, OP_COPY: begin
                  // copy with dest set rewrites the same value
                  if (st.instr[`DEST_BIT]) begin
                     next_st.wr.we = 1'b1;
                  end else begin
                     next_st.acc = st.result;
                  end
                  next_st.zero = (st.result == 8'h00);
               end
               OP_LIT: next_st.acc = st.result;
               OP_STORE: next_st.wr.we = 1'b1;
               default: next_st.acc = st.acc;
            endcase
         end
         default: next_st.phase = PH_DECODE;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st       <= '0;
         st.acc   <= `ACC_RESET;
         st.zero  <= `ZERO_RESET;
         st.phase <= PH_DECODE;
         st.op    <= OP_NONE;
      end else begin
         st <= next_st;
      end
   end

   assign instr_ready_out = (st.phase == PH_DECODE);
   assign file_raddr_out  = st.instr[6:0];
   assign file_wr_out     = st.wr;
   assign acc_out         = st.acc;
   assign zero_flag_out   = st.zero;
   assign phase_out       = st.phase;

   ////////////////////////////////////////////////////////////////////
   // checks
   AST_CYCLE_FOUR: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      st.phase == PH_DECODE |=> st.phase == PH_READ ##1
      st.phase == PH_PROCESS ##1 st.phase == PH_WRITE ##1
      st.phase == PH_DECODE)
      else $error("phase sequence broken");
   AST_OR_RESULT: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      st.phase == PH_WRITE && st.op == OP_OR && !st.instr[`DEST_BIT]
      |=> st.acc == ($past(st.result)) && st.zero == (st.acc == 8'h00))
      else $error("or result to accumulator wrong");
   AST_LIT_FLAGS: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      st.phase == PH_WRITE && st.op == OP_LIT
      |=> st.acc == $past(st.instr[7:0]) && $stable(st.zero))
      else $error("literal load wrong");
   AST_LIT_DECODE: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      instr_in[13:10] == 4'hC |-> dec_op == OP_LIT)
      else $error("literal opcode not decoded");
   AST_COPY_ACC: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      st.phase == PH_WRITE && st.op == OP_COPY && !st.instr[`DEST_BIT]
      |=> st.acc == $past(st.result) && !file_wr_out.we)
      else $error("copy to accumulator wrong");
   AST_COPY_BACK: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      st.phase == PH_WRITE && st.op == OP_COPY && st.instr[`DEST_BIT]
      |=> file_wr_out.we && file_wr_out.addr == $past(st.instr[6:0])
      && $stable(st.acc))
      else $error("copy back to register wrong");
   AST_COPY_ZERO: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      st.phase == PH_WRITE && st.op == OP_COPY
      |=> st.zero == ($past(st.result) == 8'h00))
      else $error("copy zero flag wrong");
   AST_STORE: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      st.phase == PH_WRITE && st.op == OP_STORE
      |=> file_wr_out.we && file_wr_out.data == st.acc && $stable(st.zero))
      else $error("store accumulator wrong");
   // write-back decision, shared by AST_WE_SOURCE and AST_NO_WRITE below
   function automatic logic to_file(input op_type op, input logic dest);
      return (op == OP_STORE) || ((op == OP_OR || op == OP_COPY) && dest);
   endfunction
   AST_OR_BACK: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      st.phase == PH_WRITE && st.op == OP_OR && st.instr[`DEST_BIT]
      |=> file_wr_out.we && file_wr_out.data == $past(st.result)
      && $stable(st.acc))
      else $error("or result to register wrong");
   AST_OR_ZERO: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      st.phase == PH_WRITE && st.op == OP_OR
      |=> st.zero == ($past(st.result) == 8'h00))
      else $error("or zero flag wrong");
   AST_LIT_OPERAND: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      st.phase == PH_DECODE && dec_op == OP_LIT
      |=> st.op == OP_LIT && st.instr[7:0] == $past(instr_in[7:0]))
      else $error("literal not latched");
   AST_OPERAND: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      st.phase == PH_READ && st.op != OP_LIT
      |=> st.operand == $past(file_rdata_in))
      else $error("file operand not captured");
   AST_COPY_SAME: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      st.phase == PH_WRITE && st.op == OP_COPY && st.instr[`DEST_BIT]
      |=> file_wr_out.data == $past(st.operand))
      else $error("copy back changed the value");
   AST_STORE_ADDR: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      st.phase == PH_WRITE && st.op == OP_STORE
      |=> file_wr_out.addr == $past(st.instr[6:0]) && $stable(st.acc))
      else $error("store address wrong");
   AST_WE_SOURCE: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      file_wr_out.we
      |-> $past(st.phase == PH_WRITE && to_file(st.op, st.instr[`DEST_BIT])))
      else $error("unexpected register write");
   AST_NO_WRITE: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      st.phase == PH_WRITE && !to_file(st.op, st.instr[`DEST_BIT])
      |=> !file_wr_out.we)
      else $error("write without a file destination");
   AST_NONE_IDLE: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      st.phase == PH_WRITE && st.op == OP_NONE
      |=> $stable(st.acc) && $stable(st.zero))
      else $error("unknown opcode changed state");
   AST_WE_PULSE: assert property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      file_wr_out.we |=> !file_wr_out.we)
      else $error("write pulse longer than one cycle");
   COV_OR: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
      st.phase == PH_WRITE && st.op == OP_OR);
   COV_LIT: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
      st.phase == PH_WRITE && st.op == OP_LIT);
   COV_COPY_BACK: cover property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      st.phase == PH_WRITE && st.op == OP_COPY && st.instr[`DEST_BIT]);
   COV_STORE: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
      file_wr_out.we && st.op == OP_STORE);
   COV_COPY_ZERO: cover property (@(posedge ref_clk_in)
      disable iff (!rstn_in)
      st.phase == PH_WRITE && st.op == OP_COPY && st.result == 8'h00);
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the move/or execution block
// assumes mvor_pkg and mvor_consts.svh, tb drives the file port
`timescale 1ns/1ps
`default_nettype none
`include "mvor_consts.svh"
module tb_top
   import mvor_pkg::*;
;
   typedef struct packed {
      logic [7:0]     acc;
      logic           zero;
      file_write_type wr;
      logic [6:0]     ra;
   } exp_type;
   logic           clk;
   logic           rstn;
   logic [13:0]    instr;
   logic           ready;
   logic [6:0]     raddr;
   file_write_type wr;
   logic [7:0]     acc;
   logic           zero;
   phase_type      phase;
   logic [7:0]     regs [128];
   logic [7:0]     mreg [128];
   logic [7:0]     m_acc;
   logic           m_zero;
   logic [31:0]    seed;
   int             n_fail;
   int             compares;
   exp_type        q [$];
////////////////////////////////////////
   mvor_exec uut (
      .ref_clk_in      (clk),
      .rstn_in         (rstn),
      .instr_in        (instr),
      .instr_ready_out (ready),
      .file_raddr_out  (raddr),
      .file_rdata_in   (regs[raddr]),
      .file_wr_out     (wr),
      .acc_out         (acc),
      .zero_flag_out   (zero),
      .phase_out       (phase)
   );
   always #12.5 clk = ~clk;
   // register file stand-in, written by the pulse
   always @(posedge clk) if (wr.we === 1'b1) regs[wr.addr] <= wr.data;
////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   task automatic chk(input string n, input logic [15:0] e, s);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   // op: 0 or, 1 literal, 2 copy, 3 store, else unknown opcode
   task automatic run(input int op, input logic d, input logic [6:0] f,
                      input logic [7:0] k, input logic [1:0] dc);
      exp_type     e;
      logic [7:0]  r;
      logic [13:0] enc;
      e = '0;
      r = 8'h00;
      enc = 14'h0000;
      case (op)
         0: begin
            r = m_acc | mreg[f];
            enc = {`OPC_OR_TOP, d, f};
         end
         1: begin
            m_acc = k;
            enc = {`OPC_LIT_TOP, dc, k};
         end
         2: begin
            r = mreg[f];
            enc = {`OPC_COPY_TOP, d, f};
         end
         3: begin
            r = m_acc;
            enc = {`OPC_STORE_TOP, f};
         end
         default: ;
      endcase
      e.ra = enc[6:0];
      if (op == 0 || op == 2) m_zero = (r == 8'h00);
      if (op == 3 || ((op == 0 || op == 2) && d)) begin
         mreg[f] = r;
         e.wr = {1'b1, f, r};
      end else if (op == 0 || op == 2) m_acc = r;
      e.acc = m_acc;
      e.zero = m_zero;
      @(negedge clk);
      while (phase !== PH_DECODE) @(negedge clk);
      instr = enc;
      q.push_back(e);
      @(negedge clk);
      // garbage outside decode must be ignored
      instr = 14'(rnd());
   endtask
////////////////////////////////////////
   // results land one full instruction cycle later, at next decode
   always @(posedge clk) begin
      exp_type e;
      #2;
      if (phase === PH_DECODE && q.size() > 0) begin
         e = q.pop_front();
         chk("ready", 16'h0001, 16'(ready));
         chk("raddr", 16'(e.ra), 16'(raddr));
         chk("acc", 16'(e.acc), 16'(acc));
         chk("zero", 16'(e.zero), 16'(zero));
         chk("we", 16'(e.wr.we), 16'(wr.we));
         if (e.wr.we) chk("wr", e.wr, wr);
      end
   end
   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      final_report();
   end
   initial begin
      logic [31:0] s;
      clk = 1'b0;
      rstn = 1'b0;
      instr = 14'h0000;
      seed = 32'hF287BA24;
      n_fail = 0;
      compares = 0;
      m_acc = 8'h00;
      m_zero = 1'b0;
      for (int i = 0; i < 128; i++) begin
         mreg[i] = 8'(rnd());
         regs[i] = mreg[i];
      end
      repeat (5) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      run(1, 0, 0, 8'h00, 2'b11);
      run(3, 0, 7'h10, 0, 0);
      run(0, 0, 7'h10, 0, 0);
      run(2, 1, 7'h10, 0, 0);
      run(1, 0, 0, 8'hFF, 2'b10);
      run(3, 0, 7'h7F, 0, 0);
      run(2, 0, 7'h7F, 0, 0);
      run(0, 1, 7'h10, 0, 0);
      run(7, 0, 0, 0, 0);
      run(2, 0, 7'h10, 0, 0);
      $display("test directed done");
      for (int i = 0; i < 200; i++) begin
         s = rnd();
         run(int'(s[2:0]) % 5, s[3], s[10:4], s[18:11], s[20:19]);
      end
      for (int i = 0; i < 10 && q.size() > 0; i++) @(negedge clk);
      if (q.size() > 0) n_fail++;
      $display("test random done");
      final_report();
   end
endmodule
`default_nettype wire
